// [hdl/srr_pkg.sv]
package srr_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_WORK    = 8'h04;
  localparam logic [7:0] OFS_FLAGS   = 8'h08;
  localparam logic [7:0] OFS_BANK    = 8'h0c;
  localparam logic [7:0] OFS_WORK_SH = 8'h10;
  localparam logic [7:0] OFS_FLAG_SH = 8'h14;
  localparam logic [7:0] OFS_BANK_SH = 8'h18;
  localparam logic [7:0] OFS_PC      = 8'h1c;
  localparam logic [7:0] OFS_LATCH   = 8'h20;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_EXT_BIT = 0;
  localparam int FLG_C        = 0;
  localparam int FLG_Z        = 2;
  localparam int FLG_N        = 4;
  localparam int LATU_LSB     = 8;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [4:0]  RST_FLAG = 5'h00;
  localparam logic [3:0]  RST_BANK = 4'h0;
  localparam logic [20:0] RST_PC   = 21'h000000;

  // ==========================================================
  // Opcodes and addressing
  localparam logic [14:0] OPC_RETURN   = 15'h0009;
  localparam logic [5:0]  OPC_ROT_LC   = 6'h0d;
  localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;

  typedef enum logic [0:0] {
    SRR_RUN,
    SRR_RET_WAIT
  } srr_state_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } srr_fwr_t;

endpackage : srr_pkg

// [hdl/srr_core.sv]
`timescale 1ns/1ns
module srr_core
  import srr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  input  wire logic [20:0] return_stack_top,
  output logic             stack_pop,
  input  wire logic [11:0] index_base,
  output logic      [11:0] file_raddr,
  input  wire logic [7:0]  file_rdata,
  output srr_fwr_t         file_wr
);

  // ==========================================================
  // Core state
  srr_state_t  state_r, state_nxt;
  logic        ext_en_r, ext_en_nxt;
  logic [7:0]  work_r, work_nxt, work_sh_r, work_sh_nxt;
  logic [4:0]  flags_r, flags_nxt, flags_sh_r, flags_sh_nxt;
  logic [3:0]  bank_r, bank_nxt, bank_sh_r, bank_sh_nxt;
  logic [20:0] pc_r, pc_nxt;
  logic [7:0]  pc_high_latch_r, pc_high_latch_nxt;
  logic [4:0]  pc_upper_latch_r, pc_upper_latch_nxt;
  srr_fwr_t    fwr_r, fwr_nxt;

  // Bus state
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic        take, ret_take, rot_take, shadow_sel, dest_f, acc_bsr;
  logic [7:0]  fadr, rot_res;
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign take       = instr_valid && instr_ready;
  assign ret_take   = take && (instr_word[15:1] == OPC_RETURN);
  assign rot_take   = take && (instr_word[15:10] == OPC_ROT_LC);
  assign shadow_sel = instr_word[0];
  assign dest_f     = instr_word[9];
  assign acc_bsr    = instr_word[8];
  assign fadr       = instr_word[7:0];

  // Return holds the decoder one extra cycle, as the second word slot
  assign instr_ready = (state_r == SRR_RUN);
  assign stack_pop   = ret_take;

  // ==========================================================
  // File address: banked, access bank or indexed
  always_comb begin
    if (acc_bsr) begin
      file_raddr = {bank_r, fadr};
    end else if (ext_en_r && (fadr <= IDX_LIMIT)) begin
      file_raddr = index_base + {4'h0, fadr};
    end else if (fadr <= IDX_LIMIT) begin
      file_raddr = {ACC_LO_BANK, fadr};
    end else begin
      file_raddr = {ACC_HI_BANK, fadr};
    end
  end

  assign rot_res = {file_rdata[6:0], flags_r[FLG_C]};

  // ==========================================================
  // Bus read mux
  always_comb begin
    addr_ok = 1'b1;
    case (haddr[7:0])
      OFS_CTRL:    rd_mux = {31'h0, ext_en_r};
      OFS_WORK:    rd_mux = {24'h0, work_r};
      OFS_FLAGS:   rd_mux = {27'h0, flags_r};
      OFS_BANK:    rd_mux = {28'h0, bank_r};
      OFS_WORK_SH: rd_mux = {24'h0, work_sh_r};
      OFS_FLAG_SH: rd_mux = {27'h0, flags_sh_r};
      OFS_BANK_SH: rd_mux = {28'h0, bank_sh_r};
      OFS_PC:      rd_mux = {11'h0, pc_r};
      OFS_LATCH:   rd_mux = {19'h0, pc_upper_latch_r, pc_high_latch_r};
      default: begin
        rd_mux  = 32'h0;
        addr_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Next state: bus writes first, instruction effects override
  always_comb begin
    state_nxt          = state_r;
    ext_en_nxt         = ext_en_r;
    work_nxt           = work_r;
    flags_nxt          = flags_r;
    bank_nxt           = bank_r;
    work_sh_nxt        = work_sh_r;
    flags_sh_nxt       = flags_sh_r;
    bank_sh_nxt        = bank_sh_r;
    pc_nxt             = pc_r;
    pc_high_latch_nxt  = pc_high_latch_r;
    pc_upper_latch_nxt = pc_upper_latch_r;
    fwr_nxt            = '{we: 1'b0, addr: file_raddr, data: rot_res};
    wr_pend_nxt        = hsel && htrans[1] && hready && hwrite;
    wr_addr_nxt        = haddr[7:0];
    rdata_nxt          = (hsel && htrans[1] && hready && !hwrite && addr_ok) ? rd_mux : 32'h0;

    if (wr_pend_r) begin
      case (wr_addr_r)
        OFS_CTRL:    ext_en_nxt   = hwdata[CTRL_EXT_BIT];
        OFS_WORK:    work_nxt     = hwdata[7:0];
        OFS_FLAGS:   flags_nxt    = hwdata[4:0];
        OFS_BANK:    bank_nxt     = hwdata[3:0];
        OFS_WORK_SH: work_sh_nxt  = hwdata[7:0];
        OFS_FLAG_SH: flags_sh_nxt = hwdata[4:0];
        OFS_BANK_SH: bank_sh_nxt  = hwdata[3:0];
        OFS_LATCH: begin
          pc_high_latch_nxt  = hwdata[7:0];
          pc_upper_latch_nxt = hwdata[LATU_LSB +: 5];
        end
        default: ;
      endcase
    end

    case (state_r)
      SRR_RUN: begin
        if (ret_take) begin
          pc_nxt    = return_stack_top;
          state_nxt = SRR_RET_WAIT;
          if (shadow_sel) begin
            work_nxt  = work_sh_r;
            flags_nxt = flags_sh_r;
            bank_nxt  = bank_sh_r;
          end
        end else if (rot_take) begin
          flags_nxt[FLG_C] = file_rdata[7];
          flags_nxt[FLG_Z] = (rot_res == 8'h00);
          flags_nxt[FLG_N] = rot_res[7];
          if (dest_f) begin
            fwr_nxt.we = 1'b1;
          end else begin
            work_nxt = rot_res;
          end
        end
      end
      SRR_RET_WAIT: state_nxt = SRR_RUN;
      default:      state_nxt = SRR_RUN;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r          <= SRR_RUN;
      ext_en_r         <= 1'b0;
      work_r           <= RST_BYTE;
      flags_r          <= RST_FLAG;
      bank_r           <= RST_BANK;
      work_sh_r        <= RST_BYTE;
      flags_sh_r       <= RST_FLAG;
      bank_sh_r        <= RST_BANK;
      pc_r             <= RST_PC;
      pc_high_latch_r  <= RST_BYTE;
      pc_upper_latch_r <= RST_FLAG;
      fwr_r            <= '0;
      wr_pend_r        <= 1'b0;
      wr_addr_r        <= RST_BYTE;
      rdata_r          <= 32'h0;
    end else begin
      state_r          <= state_nxt;
      ext_en_r         <= ext_en_nxt;
      work_r           <= work_nxt;
      flags_r          <= flags_nxt;
      bank_r           <= bank_nxt;
      work_sh_r        <= work_sh_nxt;
      flags_sh_r       <= flags_sh_nxt;
      bank_sh_r        <= bank_sh_nxt;
      pc_r             <= pc_nxt;
      pc_high_latch_r  <= pc_high_latch_nxt;
      pc_upper_latch_r <= pc_upper_latch_nxt;
      fwr_r            <= fwr_nxt;
      wr_pend_r        <= wr_pend_nxt;
      wr_addr_r        <= wr_addr_nxt;
      rdata_r          <= rdata_nxt;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign file_wr   = fwr_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ret_pc;
    logic [20:0] t;
    (ret_take, t = return_stack_top) |-> stack_pop ##1 (pc_r == t);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");

  property p_ret_shadow;
    ret_take && shadow_sel && !wr_pend_r |=>
      work_r == $past(work_sh_r) && flags_r == $past(flags_sh_r) && bank_r == $past(bank_sh_r);
  endproperty
  a_ret_shadow: assert property (p_ret_shadow) else $error("shadow restore wrong");

  property p_ret_keep;
    ret_take && !shadow_sel && !wr_pend_r |=> $stable(work_r) && $stable(bank_r);
  endproperty
  a_ret_keep: assert property (p_ret_keep) else $error("return changed work/bank");

  property p_ret_decode;
    instr_valid && instr_ready && instr_word[15:1] == OPC_RETURN |->
      stack_pop ##1 !instr_ready ##1 instr_ready;
  endproperty
  a_ret_decode: assert property (p_ret_decode) else $error("return decode wrong");

  property p_ret_latch;
    ret_take && !wr_pend_r |=> $stable(pc_high_latch_r) && $stable(pc_upper_latch_r);
  endproperty
  a_ret_latch: assert property (p_ret_latch) else $error("pc latch changed");

  property p_rot_carry;
    rot_take && !wr_pend_r |=> flags_r[FLG_C] == $past(file_rdata[7]);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("carry wrong");

  property p_rot_dest;
    rot_take && dest_f |=> file_wr.we && file_wr.data == {$past(file_rdata[6:0]),
      $past(flags_r[FLG_C])} && file_wr.addr == $past(file_raddr);
  endproperty
  a_rot_dest: assert property (p_rot_dest) else $error("file write wrong");

  property p_rot_bank;
    rot_take && acc_bsr |-> file_raddr == {bank_r, fadr};
  endproperty
  a_rot_bank: assert property (p_rot_bank) else $error("banked address wrong");

  property p_rot_idx;
    rot_take && !acc_bsr && ext_en_r && fadr <= IDX_LIMIT |->
      file_raddr == index_base + {4'h0, fadr};
  endproperty
  a_rot_idx: assert property (p_rot_idx) else $error("indexed address wrong");

  property p_ret_flags;
    ret_take && !shadow_sel && !wr_pend_r |=> $stable(flags_r);
  endproperty
  a_ret_flags: assert property (p_ret_flags) else $error("return changed flags");

  property p_rot_zn;
    rot_take && !dest_f && !wr_pend_r |=> instr_ready && flags_r[FLG_Z] == (work_r == 8'h00)
      && flags_r[FLG_N] == work_r[7];
  endproperty
  a_rot_zn: assert property (p_rot_zn) else $error("zero/negative wrong");

  c_ret_shadow: cover property (ret_take && shadow_sel);
  c_rot_work:   cover property (rot_take && !dest_f);
  c_rot_idx:    cover property (rot_take && !acc_bsr && ext_en_r && fadr <= IDX_LIMIT);
  c_bus_rd:     cover property (hsel && htrans[1] && !hwrite ##1 hrdata != 32'h0);

endmodule : srr_core

// [bench/test_subroutine_return_and_carry_rotate.sv]
`timescale 1ns/1ns
module test_subroutine_return_and_carry_rotate
  import srr_pkg::*;
;
  // ==========================================================
  // Signals
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic        instr_ready;
  logic [20:0] top;
  logic        stack_pop;
  logic [11:0] index_base;
  logic [11:0] file_raddr;
  logic [7:0]  file_rdata;
  srr_fwr_t    file_wr;
  int          num_errors;
  int          comparisons;
  int          cyc;
  logic [31:0] rd;
  logic        sp;
  logic        rdy;
  logic [11:0] ra;
  srr_fwr_t    fw;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  srr_core DUT (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hready),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .instr_valid      (instr_valid),
    .instr_word       (instr_word),
    .instr_ready      (instr_ready),
    .return_stack_top (top),
    .stack_pop        (stack_pop),
    .index_base       (index_base),
    .file_raddr       (file_raddr),
    .file_rdata       (file_rdata),
    .file_wr          (file_wr)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ==========================================================
  // Helpers
  task summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Each phase held until hready is seen high at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp, what);
  endtask : rchk

  task exe(input logic [15:0] word);
    instr_valid <= 1'b1;
    instr_word  <= word;
    @(posedge hclk);
    while (instr_ready !== 1'b1) @(posedge hclk);
    sp = stack_pop;
    ra = file_raddr;
    instr_valid <= 1'b0;
    @(posedge hclk);
    fw  = file_wr;
    rdy = instr_ready;
  endtask : exe

  // ==========================================================
  // Scenarios
  task t_ret();
    rchk(OFS_PC, 32'h00000000, "pc reset");
    bus(1'b1, OFS_WORK_SH, 32'h000000a5);
    bus(1'b1, OFS_FLAG_SH, 32'h0000001f);
    bus(1'b1, OFS_BANK_SH, 32'h00000003);
    bus(1'b1, OFS_LATCH, 32'h00001534);
    bus(1'b1, OFS_WORK, 32'h00000011);
    bus(1'b1, OFS_FLAGS, 32'h0000000a);
    bus(1'b1, OFS_BANK, 32'h00000002);
    top <= 21'h1abcde;
    exe(16'h0013);
    chk(32'(sp), 32'h00000001, "pop");
    chk(32'(rdy), 32'h00000000, "dead cycle");
    rchk(OFS_PC, 32'h001abcde, "pc");
    rchk(OFS_WORK, 32'h000000a5, "work");
    rchk(OFS_FLAGS, 32'h0000001f, "flags");
    rchk(OFS_BANK, 32'h00000003, "bank");
    rchk(OFS_LATCH, 32'h00001534, "latch");
    bus(1'b1, OFS_WORK, 32'h00000022);
    bus(1'b1, OFS_BANK, 32'h00000007);
    // Flags differ from their shadow so a wrong restore shows
    bus(1'b1, OFS_FLAGS, 32'h00000005);
    top <= 21'h000246;
    exe(16'h0012);
    chk(32'(sp), 32'h00000001, "pop");
    rchk(OFS_PC, 32'h00000246, "pc");
    rchk(OFS_WORK, 32'h00000022, "work");
    rchk(OFS_FLAGS, 32'h00000005, "flags");
    rchk(OFS_BANK, 32'h00000007, "bank");
    rchk(OFS_LATCH, 32'h00001534, "latch");
    // Neighbouring opcode must not be taken as a return
    exe(16'h0014);
    chk(32'(sp), 32'h00000000, "no pop");
    rchk(OFS_PC, 32'h00000246, "pc kept");
    $display("test return done");
  endtask : t_ret

  task rot(input logic [15:0] word, input logic cin, input logic [3:0] bank,
           input logic ext, input logic [7:0] rdat, input logic [11:0] eaddr);
    logic [7:0] res;
    logic [4:0] ef;
    res = {rdat[6:0], cin};
    ef  = {res[7], 1'b0, res == 8'h00, 1'b0, rdat[7]};
    bus(1'b1, OFS_FLAGS, 32'(cin));
    bus(1'b1, OFS_BANK, 32'(bank));
    bus(1'b1, OFS_CTRL, 32'(ext));
    bus(1'b1, OFS_WORK, 32'h0000005a);
    file_rdata <= rdat;
    exe(word);
    chk(32'(ra), 32'(eaddr), "file address");
    rchk(OFS_FLAGS, 32'(ef), "flags");
    if (word[9]) begin
      chk(32'(fw), 32'({1'b1, eaddr, res}), "file write");
      rchk(OFS_WORK, 32'h0000005a, "work kept");
    end else begin
      chk(32'(fw.we), 32'h00000000, "no write");
      rchk(OFS_WORK, 32'(res), "work");
    end
  endtask : rot

  task t_rot();
    index_base <= 12'hfe0;
    rot(16'h37ff, 1'b0, 4'h5, 1'b0, 8'h80, 12'h5ff);
    rot(16'h3460, 1'b0, 4'h5, 1'b0, 8'he6, 12'hf60);
    rot(16'h345f, 1'b1, 4'h5, 1'b0, 8'h01, 12'h05f);
    rot(16'h365f, 1'b1, 4'h5, 1'b1, 8'h7f, 12'h03f);
    rot(16'h3660, 1'b0, 4'h5, 1'b1, 8'h00, 12'hf60);
    rot(16'h375f, 1'b0, 4'h9, 1'b1, 8'h40, 12'h95f);
    $display("test rotate done");
  endtask : t_rot

  // ==========================================================
  // Main sequence
  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h00000000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h00000000;
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    top         = 21'h000000;
    index_base  = 12'h000;
    file_rdata  = 8'h00;
    num_errors  = 0;
    comparisons = 0;
    cyc         = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_ret();
    t_rot();
    summarize();
  end
endmodule : test_subroutine_return_and_carry_rotate
